// ### rtl/cdma_pkg.sv
package cdma_pkg;

  // ---------------------------------------------------------------
  // Register offsets inside the relocatable I/O block
  // ---------------------------------------------------------------
  localparam logic [3:0] CDMA_OFS_ADDR0 = 4'h0;
  localparam logic [3:0] CDMA_OFS_ADDR1 = 4'h1;
  localparam logic [3:0] CDMA_OFS_ADDR2 = 4'h2;
  localparam logic [3:0] CDMA_OFS_ADDR3 = 4'h3;
  localparam logic [3:0] CDMA_OFS_CNT0 = 4'h4;
  localparam logic [3:0] CDMA_OFS_CNT1 = 4'h5;
  localparam logic [3:0] CDMA_OFS_CNT2 = 4'h6;
  localparam logic [3:0] CDMA_OFS_CMD_STAT = 4'h8;
  localparam logic [3:0] CDMA_OFS_SOFT_REQ = 4'h9;
  localparam logic [3:0] CDMA_OFS_MODE = 4'hb;
  localparam logic [3:0] CDMA_OFS_MCLEAR = 4'hd;
  localparam logic [3:0] CDMA_OFS_MASK = 4'hf;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CDMA_CMD_DISABLE_BIT = 2;
  localparam int CDMA_SOFT_REQ_BIT = 2;
  localparam int CDMA_MASK_BIT = 0;
  localparam int CDMA_MODE_REQ_LSB = 6;
  localparam int CDMA_MODE_DEC_BIT = 5;
  localparam int CDMA_MODE_AUTO_BIT = 4;
  localparam int CDMA_MODE_TYPE_LSB = 2;
  localparam int CDMA_BLK_SHIFT = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CDMA_ADDR_RST = 32'h0000_0000;
  localparam logic [23:0] CDMA_CNT_RST = 24'h00_0000;
  localparam logic [7:0] CDMA_MODE_RST = 8'h00;
  localparam logic CDMA_MASK_RST = 1'b1;
  localparam logic [7:0] CDMA_TOP_FORCED = 8'h00;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CDMA_SEL_OFF = 2'h0;
  localparam logic [1:0] CDMA_SEL_INPUT_ACK = 2'h1;
  localparam logic [1:0] CDMA_SEL_PROTECT_IO16 = 2'h2;
  localparam logic [1:0] CDMA_SEL_BATTERY_SPEAKER = 2'h3;

  typedef enum logic [1:0] {
    CDMA_REQ_DEMAND,
    CDMA_REQ_SINGLE,
    CDMA_REQ_BLOCK,
    CDMA_REQ_NONE
  } cdma_req_mode_e;

  typedef enum logic [1:0] {
    CDMA_TYPE_VERIFY,
    CDMA_TYPE_WRITE,
    CDMA_TYPE_READ,
    CDMA_TYPE_RSVD
  } cdma_xfer_type_e;

  // Byte-wide I/O request from the legacy DMA master
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cdma_io_req_s;

  // Slave configuration and card control settings
  typedef struct packed {
    logic [15:0] base;
    logic wide_addr;
    logic xfer16;
    logic request_polarity;
    logic [1:0] dma_enable;
  } cdma_cfg_s;

endpackage

// ### rtl/cdma_slave.sv
`timescale 1ns/1ps
module cdma_slave
  import cdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire cdma_io_req_s io_req_i,
  input wire cdma_cfg_s cfg_i,
  input wire logic card_input_ack_i,
  input wire logic card_protect_io16_i,
  input wire logic card_battery_speaker_i,
  input wire logic xfer_done_i,
  output logic [7:0] io_rdata_o,
  output logic io_hit_o,
  output logic dma_req_o,
  output logic [31:0] mem_addr_o,
  output logic xfer_to_mem_o,
  output logic terminal_count_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0][2:0] pin_sync;
    logic [2:0] pin_lvl;
    logic [31:0] base_addr;
    logic [31:0] cur_addr;
    logic [23:0] base_cnt;
    logic [23:0] cur_cnt;
    logic cmd_disable;
    logic [7:0] mode;
    logic mask;
    logic tc_flag;
    logic soft_req;
    logic block_run;
    logic single_gap;
    logic [7:0] rdata;
    logic hit;
    logic req;
    logic [31:0] mem_addr;
    logic to_mem;
    logic tc_pulse;
  } cdma_state_s;

  // Registered state, its next value and the reset image
  cdma_state_s st_ff;
  cdma_state_s nxt_st;
  cdma_state_s rst_st;

  // Combinational helpers
  logic [2:0] pins;
  logic sel_lvl;
  logic card_req;
  logic io_hit;
  logic [3:0] ofs;
  logic wr;
  logic rd;
  logic last;
  logic [23:0] cnt_dec;
  logic [31:0] addr_step;
  logic [7:0] top_byte;
  cdma_req_mode_e req_mode;
  cdma_xfer_type_e xfer_type;
  logic served;

  assign pins = {card_battery_speaker_i, card_protect_io16_i, card_input_ack_i};
  assign req_mode = cdma_req_mode_e'(st_ff.mode[CDMA_MODE_REQ_LSB +: 2]);
  assign xfer_type = cdma_xfer_type_e'(st_ff.mode[CDMA_MODE_TYPE_LSB +: 2]);

  // Reset image, shared by rst_i and the master-clear write
  always_comb begin
    rst_st = '0;
    rst_st.base_addr = CDMA_ADDR_RST;
    rst_st.cur_addr = CDMA_ADDR_RST;
    rst_st.base_cnt = CDMA_CNT_RST;
    rst_st.cur_cnt = CDMA_CNT_RST;
    rst_st.mode = CDMA_MODE_RST;
    rst_st.mask = CDMA_MASK_RST;
  end

  // ---------------------------------------------------------------
  // Request selection and register decode
  // ---------------------------------------------------------------
  always_comb begin
    // Block decode: only the upper twelve address bits take part
    io_hit = io_req_i.addr[15:CDMA_BLK_SHIFT] == cfg_i.base[15:CDMA_BLK_SHIFT];
    ofs = io_req_i.addr[3:0];
    wr = io_req_i.wr & io_hit;
    rd = io_req_i.rd & io_hit;
    // Route the chosen card pin
    case (cfg_i.dma_enable)
      CDMA_SEL_INPUT_ACK: sel_lvl = st_ff.pin_lvl[0];
      CDMA_SEL_PROTECT_IO16: sel_lvl = st_ff.pin_lvl[1];
      CDMA_SEL_BATTERY_SPEAKER: sel_lvl = st_ff.pin_lvl[2];
      default: sel_lvl = 1'b0;
    endcase
    // Polarity applied; pin ignored while DMA is off
    card_req = (cfg_i.dma_enable != CDMA_SEL_OFF) &&
               (cfg_i.request_polarity ? sel_lvl : ~sel_lvl);
    // Count runs to zero and then one more; wide count only with wide addressing
    last = cfg_i.wide_addr ? (st_ff.cur_cnt == 24'h00_0000)
                           : (st_ff.cur_cnt[15:0] == 16'h0000);
    // Count step, top byte held at zero for the legacy count width
    cnt_dec = st_ff.cur_cnt - 24'h00_0001;
    if (!cfg_i.wide_addr) begin
      cnt_dec[23:16] = 8'h00;
    end
    // Next address one unit up or down
    addr_step = st_ff.mode[CDMA_MODE_DEC_BIT] ? st_ff.cur_addr - 32'h0000_0001
                                              : st_ff.cur_addr + 32'h0000_0001;
    // A done pulse counts only while the request stands
    served = xfer_done_i & st_ff.req;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // One-cycle outputs fall back unless set again below
    nxt_st.tc_pulse = 1'b0;
    nxt_st.hit = io_req_i.rd & io_hit;
    nxt_st.single_gap = 1'b0;

    // Three-stage pin sampling; level moves once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      nxt_st.pin_sync[i] = {st_ff.pin_sync[i][1:0], pins[i]};
      if (st_ff.pin_sync[i][1] == st_ff.pin_sync[i][2]) begin
        nxt_st.pin_lvl[i] = st_ff.pin_sync[i][2];
      end
    end

    // Read data: current values, reserved and write-only read zero
    nxt_st.rdata = 8'h00;
    if (rd) begin
      case (ofs)
        CDMA_OFS_ADDR0: nxt_st.rdata = st_ff.cur_addr[7:0];
        CDMA_OFS_ADDR1: nxt_st.rdata = st_ff.cur_addr[15:8];
        CDMA_OFS_ADDR2: nxt_st.rdata = st_ff.cur_addr[23:16];
        CDMA_OFS_ADDR3: nxt_st.rdata = st_ff.cur_addr[31:24];
        CDMA_OFS_CNT0: nxt_st.rdata = st_ff.cur_cnt[7:0];
        CDMA_OFS_CNT1: nxt_st.rdata = st_ff.cur_cnt[15:8];
        CDMA_OFS_CNT2: nxt_st.rdata = st_ff.cur_cnt[23:16];
        CDMA_OFS_CMD_STAT: nxt_st.rdata = {{4{~card_req}}, {4{st_ff.tc_flag}}};
        CDMA_OFS_MODE: nxt_st.rdata = st_ff.mode;
        CDMA_OFS_MASK: nxt_st.rdata = {7'h00, st_ff.mask};
        default: nxt_st.rdata = 8'h00;
      endcase
      // Status read consumes the terminal-count flag
      if (ofs == CDMA_OFS_CMD_STAT) begin
        nxt_st.tc_flag = 1'b0;
      end
    end

    // Address and count writes load base values and their current copies; other writes set their own field
    if (wr) begin
      case (ofs)
        CDMA_OFS_ADDR0: begin
          nxt_st.base_addr[7:0] = io_req_i.wdata;
          nxt_st.cur_addr[7:0] = io_req_i.wdata;
        end
        CDMA_OFS_ADDR1: begin
          nxt_st.base_addr[15:8] = io_req_i.wdata;
          nxt_st.cur_addr[15:8] = io_req_i.wdata;
        end
        CDMA_OFS_ADDR2: begin
          nxt_st.base_addr[23:16] = io_req_i.wdata;
          nxt_st.cur_addr[23:16] = io_req_i.wdata;
        end
        CDMA_OFS_ADDR3: begin
          nxt_st.base_addr[31:24] = io_req_i.wdata;
          nxt_st.cur_addr[31:24] = io_req_i.wdata;
        end
        CDMA_OFS_CNT0: begin
          nxt_st.base_cnt[7:0] = io_req_i.wdata;
          nxt_st.cur_cnt[7:0] = io_req_i.wdata;
        end
        CDMA_OFS_CNT1: begin
          nxt_st.base_cnt[15:8] = io_req_i.wdata;
          nxt_st.cur_cnt[15:8] = io_req_i.wdata;
        end
        CDMA_OFS_CNT2: begin
          nxt_st.base_cnt[23:16] = io_req_i.wdata;
          nxt_st.cur_cnt[23:16] = io_req_i.wdata;
        end
        CDMA_OFS_CMD_STAT: nxt_st.cmd_disable = io_req_i.wdata[CDMA_CMD_DISABLE_BIT];
        CDMA_OFS_SOFT_REQ: nxt_st.soft_req = io_req_i.wdata[CDMA_SOFT_REQ_BIT];
        CDMA_OFS_MODE: nxt_st.mode = io_req_i.wdata;
        CDMA_OFS_MASK: nxt_st.mask = io_req_i.wdata[CDMA_MASK_BIT];
        default: nxt_st.mode = nxt_st.mode;
      endcase
    end

    // Block mode starts on a card request or the software request bit
    if (req_mode == CDMA_REQ_BLOCK && !st_ff.mask && (card_req || st_ff.soft_req)) begin
      nxt_st.block_run = 1'b1;
    end

    // One transaction served by the master
    if (served) begin
      nxt_st.cur_addr = addr_step;
      nxt_st.cur_cnt = cnt_dec;
      if (req_mode == CDMA_REQ_SINGLE) begin
        nxt_st.single_gap = 1'b1;
      end
      if (last) begin
        nxt_st.tc_flag = 1'b1;
        nxt_st.tc_pulse = 1'b1;
        nxt_st.block_run = 1'b0;
        nxt_st.soft_req = 1'b0;
        if (st_ff.mode[CDMA_MODE_AUTO_BIT]) begin
          nxt_st.cur_addr = st_ff.base_addr;
          nxt_st.cur_cnt = st_ff.base_cnt;
        end else begin
          nxt_st.mask = 1'b1;
        end
      end
    end

    // Request to the system, never while off, masked or disabled
    // Single mode leaves a one-cycle gap after each transaction
    nxt_st.req = 1'b0;
    if (cfg_i.dma_enable != CDMA_SEL_OFF && !nxt_st.mask && !nxt_st.cmd_disable &&
        xfer_type != CDMA_TYPE_RSVD && !nxt_st.single_gap && !nxt_st.tc_pulse) begin
      case (req_mode)
        CDMA_REQ_DEMAND: nxt_st.req = card_req;
        CDMA_REQ_SINGLE: nxt_st.req = card_req;
        CDMA_REQ_BLOCK: nxt_st.req = nxt_st.block_run;
        default: nxt_st.req = 1'b0;
      endcase
    end

    // Memory address and direction of the next transaction
    nxt_st.to_mem = xfer_type != CDMA_TYPE_READ;
    top_byte = (nxt_st.to_mem && !cfg_i.wide_addr) ? CDMA_TOP_FORCED
                                                  : nxt_st.cur_addr[31:24];
    // 16-bit mode skips address bit 16 of the register
    if (cfg_i.xfer16) begin
      nxt_st.mem_addr = {top_byte, nxt_st.cur_addr[23:17], nxt_st.cur_addr[15:0],
                         1'b0};
    end else begin
      nxt_st.mem_addr = {top_byte, nxt_st.cur_addr[23:0]};
    end

    // Master clear writes reset the whole channel, whatever the data
    // Pin samplers are kept so that a clear does not fake a request edge;
    // the slave configuration lives outside this state and is untouched
    if (wr && ofs == CDMA_OFS_MCLEAR) begin
      nxt_st = rst_st;
      nxt_st.pin_sync = st_ff.pin_sync;
      nxt_st.pin_lvl = st_ff.pin_lvl;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Synchronous reset loads the same image as a master clear, so the two
  // paths cannot drift apart; the pin samplers restart from zero here and
  // need a few edges before a card request is seen
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_ff <= rst_st;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Outputs straight from the state register
  assign io_rdata_o = st_ff.rdata;
  assign io_hit_o = st_ff.hit;
  assign dma_req_o = st_ff.req;
  assign mem_addr_o = st_ff.mem_addr;
  assign xfer_to_mem_o = st_ff.to_mem;
  assign terminal_count_o = st_ff.tc_pulse;

endmodule

// ### tb/cdma_card_model.sv
`timescale 1ns/1ps
module cdma_card_model (
  input wire logic active_i,
  input wire logic polarity_i,
  input wire logic [1:0] sel_i,
  output logic card_input_ack_o,
  output logic card_protect_io16_o,
  output logic card_battery_speaker_o
);
  // Only the routed pin carries the request; the others rest at the idle level
  assign card_input_ack_o = (active_i && sel_i == 2'h1) ? polarity_i : !polarity_i;
  assign card_protect_io16_o = (active_i && sel_i == 2'h2) ? polarity_i : !polarity_i;
  assign card_battery_speaker_o = (active_i && sel_i == 2'h3) ? polarity_i : !polarity_i;
endmodule

// ### tb/cdma_slave_props.sv
`timescale 1ns/1ps
module cdma_slave_chk
  import cdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire cdma_io_req_s io_req_i,
  input wire cdma_cfg_s cfg_i,
  input wire logic xfer_done_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_hit_o,
  input wire logic dma_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic xfer_to_mem_o,
  input wire logic terminal_count_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Block decode against the configured base
  wire hit = io_req_i.addr[15:4] == cfg_i.base[15:4];

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence rd_at(logic [3:0] o);
    io_req_i.rd && hit && io_req_i.addr[3:0] == o;
  endsequence
  sequence off_two;
    (cfg_i.dma_enable == CDMA_SEL_OFF) [*2];
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  hit_answer_a: assert property (io_req_i.rd && hit |=> io_hit_o)
    else $error("read hit not answered");
  miss_quiet_a: assert property (io_req_i.rd && !hit |=> !io_hit_o && io_rdata_o == 8'h00)
    else $error("read miss answered");
  rsvd_zero_a: assert property (rd_at(4'h7) or rd_at(4'he) |=> io_rdata_o == 8'h00)
    else $error("reserved read not zero");
  stat_rep_a: assert property (rd_at(CDMA_OFS_CMD_STAT) |=>
    io_rdata_o[3:0] == {4{io_rdata_o[0]}} && io_rdata_o[7:4] == {4{io_rdata_o[4]}})
    else $error("status nibbles not replicated");
  off_no_req_a: assert property (off_two |-> !dma_req_o)
    else $error("request while disabled");
  tc_pulse_a: assert property (terminal_count_o |=> !terminal_count_o)
    else $error("terminal count longer than one cycle");
  tc_req_low_a: assert property (terminal_count_o |-> !dma_req_o)
    else $error("request held at terminal count");
  idle_done_a: assert property (xfer_done_i && !dma_req_o |=> !terminal_count_o)
    else $error("done counted without request");
  top_zero_a: assert property (!cfg_i.wide_addr && !$past(cfg_i.wide_addr) && xfer_to_mem_o
    |-> mem_addr_o[31:24] == CDMA_TOP_FORCED)
    else $error("top address byte not forced");
endmodule

bind cdma_slave cdma_slave_chk i_chk (.core_clk_i, .rst_i, .io_req_i, .cfg_i, .xfer_done_i,
  .io_rdata_o, .io_hit_o, .dma_req_o, .mem_addr_o, .xfer_to_mem_o, .terminal_count_o);

// ### tb/cdma_slave_tb.sv
`timescale 1ns/1ps
module cdma_slave_tb;
  import cdma_pkg::*;
  localparam logic [15:0] BASE = 16'h03a0;
  logic core_clk_i, rst_i, xfer_done_i, card_on, ia, wp, bs;
  logic io_hit_o, dma_req_o, xfer_to_mem_o, terminal_count_o;
  logic [7:0] io_rdata_o, v;
  logic [31:0] mem_addr_o;
  cdma_io_req_s io_req_i;
  cdma_cfg_s cfg_i;
  int error_cnt, comparisons;
  // Rows: offset, write data, expected read back
  logic [19:0] rows [14] = '{20'h05a5a, 20'h1c3c3, 20'h27e7e, 20'h38181, 20'h43434,
    20'h51212, 20'h60101, 20'h7ff00, 20'h90400, 20'haff00, 20'hcff00, 20'heff00,
    20'hfff01, 20'hba5a5};

  cdma_slave i_dut (.core_clk_i, .rst_i, .io_req_i, .cfg_i, .card_input_ack_i(ia),
    .card_protect_io16_i(wp), .card_battery_speaker_i(bs), .xfer_done_i, .io_rdata_o,
    .io_hit_o, .dma_req_o, .mem_addr_o, .xfer_to_mem_o, .terminal_count_o);
  cdma_card_model i_card (.active_i(card_on), .polarity_i(cfg_i.request_polarity),
    .sel_i(cfg_i.dma_enable), .card_input_ack_o(ia), .card_protect_io16_o(wp),
    .card_battery_speaker_o(bs));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    io_req_i = {1'b0, 1'b1, BASE | {12'h0, o}, d};
    tick(1);
    io_req_i = '0;
    tick(1);
  endtask
  task automatic rdc(input logic [3:0] o, input logic [7:0] exp);
    io_req_i = {1'b1, 1'b0, BASE | {12'h0, o}, 8'h00};
    tick(1);
    io_req_i = '0;
    v = io_rdata_o;
    chk({31'h0, io_hit_o}, 32'h1);
    chk({24'h0, v}, {24'h0, exp});
    tick(1);
  endtask
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 40 && dma_req_o !== lvl; i++) tick(1);
    chk({31'h0, dma_req_o}, {31'h0, lvl});
  endtask
  task automatic prog(input logic [31:0] a, input logic [7:0] m);
    for (int i = 0; i < 4; i++) wr(4'(i), a[8*i +: 8]);
    wr(CDMA_OFS_MODE, m);
    wr(CDMA_OFS_MASK, 8'h00);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Watchdog
  initial begin
    #50us;
    error_cnt++;
    conclude;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    io_req_i = '0;
    xfer_done_i = 1'b0;
    card_on = 1'b0;
    cfg_i = '{base: BASE, wide_addr: 1'b1, xfer16: 1'b0, request_polarity: 1'b1, dma_enable: 2'h0};
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    for (int o = 0; o < 7; o++) rdc(4'(o), 8'h00);
    rdc(CDMA_OFS_MASK, 8'h01);
    io_req_i = {1'b1, 1'b0, 16'h1230, 8'h00};
    tick(1);
    io_req_i = '0;
    chk({31'h0, io_hit_o}, 32'h0);
    tick(1);
    foreach (rows[r]) begin
      wr(rows[r][19:16], rows[r][15:8]);
      rdc(rows[r][19:16], rows[r][7:0]);
    end
    wr(CDMA_OFS_MCLEAR, 8'h5a);
    rdc(CDMA_OFS_ADDR0, 8'h00);
    rdc(CDMA_OFS_MASK, 8'h01);
    // Single mode, three transactions from a count of two
    cfg_i.wide_addr = 1'b0;
    cfg_i.dma_enable = CDMA_SEL_INPUT_ACK;
    prog(32'h9900_0010, 8'h44);
    wr(CDMA_OFS_CNT0, 8'h02);
    card_on = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_req(1'b1);
      chk(mem_addr_o, 32'h10 + k);
      chk({31'h0, xfer_to_mem_o}, 32'h1);
      rdc(CDMA_OFS_CNT0, 8'(2 - k));
      xfer_done_i = 1'b1;
      tick(1);
      xfer_done_i = 1'b0;
      if (k == 2) chk({31'h0, terminal_count_o}, 32'h1);
      tick(2);
    end
    rdc(CDMA_OFS_MASK, 8'h01);
    rdc(CDMA_OFS_CMD_STAT, 8'h0f);
    rdc(CDMA_OFS_CMD_STAT, 8'h00);
    card_on = 1'b0;
    // Demand mode on every pin, both polarities, both widths
    for (int s = 1; s < 4; s++) begin
      cfg_i.dma_enable = 2'(s);
      cfg_i.request_polarity = s[0];
      cfg_i.xfer16 = (s == 2);
      prog(32'h0065_4321, 8'h04);
      card_on = 1'b1;
      wait_req(1'b1);
      chk(mem_addr_o, s == 2 ? {8'h00, 7'h32, 8'h43, 8'h21, 1'b0} : 32'h0065_4321);
      card_on = 1'b0;
      wait_req(1'b0);
    end
    card_on = 1'b1;
    wr(CDMA_OFS_CMD_STAT, 8'h04);
    tick(10);
    chk({31'h0, dma_req_o}, 32'h0);
    wr(CDMA_OFS_CMD_STAT, 8'h00);
    wait_req(1'b1);
    cfg_i.dma_enable = CDMA_SEL_OFF;
    tick(3);
    xfer_done_i = 1'b1;
    tick(1);
    xfer_done_i = 1'b0;
    tick(10);
    chk({31'h0, dma_req_o}, 32'h0);
    // Block mode by software request, decrement, auto-initialize, wide addressing
    cfg_i.wide_addr = 1'b1;
    cfg_i.dma_enable = CDMA_SEL_INPUT_ACK;
    card_on = 1'b0;
    prog(32'h8800_0105, 8'hb4);
    wr(CDMA_OFS_CNT0, 8'h01);
    wr(CDMA_OFS_CNT1, 8'h00);
    wr(CDMA_OFS_CNT2, 8'h00);
    wr(CDMA_OFS_SOFT_REQ, 8'h04);
    wait_req(1'b1);
    chk(mem_addr_o, 32'h8800_0105);
    for (int k = 0; k < 2; k++) begin
      xfer_done_i = 1'b1;
      tick(1);
      xfer_done_i = 1'b0;
      chk({31'h0, terminal_count_o}, {31'h0, k == 1});
      if (k == 0) chk(mem_addr_o, 32'h8800_0104);
      if (k == 0) chk({31'h0, dma_req_o}, 32'h1);
    end
    tick(1);
    rdc(CDMA_OFS_ADDR0, 8'h05);
    rdc(CDMA_OFS_CNT0, 8'h01);
    rdc(CDMA_OFS_MASK, 8'h00);
    chk({31'h0, dma_req_o}, 32'h0);
    // Reset after the block run, with the channel still unmasked, restores the reset image
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    rdc(CDMA_OFS_CNT0, 8'h00);
    rdc(CDMA_OFS_MASK, 8'h01);
    conclude;
  end
endmodule
